// File: logic/asmc_defines.vh
// Constants for the asynchronous serial mode control block.
// Assumes a 20 MHz system clock and an 8-bit CPU data bus with 16-bit addresses.
`ifndef ASMC_DEFINES_VH
`define ASMC_DEFINES_VH

`define ASMC_ADDR_MODE        16'hFF70
`define ASMC_ADDR_BAUD        16'hFF71
`define ASMC_ADDR_RXBUF       16'hFF72
`define ASMC_ADDR_ERR         16'hFF73
`define ASMC_ADDR_TXSHIFT     16'hFF74
`define ASMC_ADDR_PORT1DIR    16'hFF21

`define ASMC_MODE_RESET       8'h01
`define ASMC_BAUD_RESET       8'h1F
`define ASMC_PORT1DIR_RESET   8'hFF
`define ASMC_ERR_RESET        8'h00

`define ASMC_BIT_POWER        7
`define ASMC_BIT_TXE          6
`define ASMC_BIT_RXE          5
`define ASMC_BIT_PS_HI        4
`define ASMC_BIT_PS_LO        3
`define ASMC_BIT_CL           2
`define ASMC_BIT_SL           1
`define ASMC_BIT_TXPIN        4
`define ASMC_BIT_RXPIN        3

`define ASMC_PS_NONE          2'b00
`define ASMC_PS_ZERO          2'b01
`define ASMC_PS_ODD           2'b10
`define ASMC_PS_EVEN          2'b11

`define ASMC_DIV_SEL1         7'd4
`define ASMC_DIV_SEL2         7'd16
`define ASMC_DIV_SEL3         7'd64

`endif

// File: logic/asmc_serial_unit.v
// Asynchronous serial unit: mode register, pin hand-over, frame transmit and receive.
// Assumes one 20 MHz clock, a CPU register port at the printed addresses, and pins
// whose port-side latches come from the port logic outside.
`include "asmc_defines.vh"

// What this block does
// [R1] Power off stops clock, resets internal registers
// [R2] Transmit enable off resets transmit circuit
// [R3] Receive enable off resets receive circuit
// [R4] Power off forces receive input high
// [R5] All bits off: stop mode, pins ports
// [R6] Software clears enables before clearing power
// [R7] Software programs baud, format, power, enables
// [R8] Software waits two base clocks before data
// [R9] Mode register resets 01H, bit0 reads one
// [R10] Direction bit 0 output, 1 input; FFH
// [R11] Transmit pin: direction output, latch one
// [R12] Receive pin: direction input, latch ignored
// [R13] Serial pin function only when enabled
// [R14] Start bit, 7/8 data bits, LSB first
// [R15] Parity even, odd, zero or none
// [R16] One or two stop bits
// [R17] Single bytes, full duplex transmit and receive
// [R18] Parity after data; idle and stops high
// [R19] Receiver checks only one stop bit
// [R20] Software waits two base clocks before re-enable
// [R21] Power on drives output idle high; tx_pin_out follows the port latch until transmit enable is also set
// [R22] Error status clears on read, reset, disable
module asmc_serial_unit (
  input  wire        clk_in,           // 20 MHz system clock
  input  wire        sys_rst_in,       // Asynchronous reset, active high
  input  wire [15:0] addr_in,          // CPU register address
  input  wire [7:0]  wr_data_in,       // CPU write data
  input  wire        wr_en_in,         // Write strobe, one cycle
  input  wire        rd_en_in,         // Read strobe, one cycle
  input  wire        timer_clk_in,     // External timer output used as base clock
  input  wire [7:0]  port1_latch_in,   // Port 1 output latches
  input  wire        rx_pin_in,        // Level on the receive pin
  output reg  [7:0]  rd_data_out,      // Read data, valid cycle after strobe
  output reg         tx_pin_out,       // Level driven on the transmit pin
  output reg         tx_pin_oe_out,    // Transmit pin driven when high
  output reg         rx_pin_out,       // Port level on the receive pin
  output reg         rx_pin_oe_out,    // Receive pin driven when high
  output reg         tx_ready_out,     // Transmit buffer can take a byte
  output reg         tx_done_out,      // Pulse after last stop bit
  output reg         rx_done_out,      // Pulse when a frame is received
  output reg         rx_err_out        // Pulse when a frame has an error
);

  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;
  localparam RX_IDLE  = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA  = 2'b10;

  reg  [7:0] serial_mode_control;
  reg  [7:0] baud_control_register;
  reg  [7:0] port1_direction;
  reg  [2:0] receive_error_status;
  reg  [7:0] receive_buffer_register;

  wire unit_power_bit          = serial_mode_control[`ASMC_BIT_POWER];
  wire transmit_enable_bit     = serial_mode_control[`ASMC_BIT_TXE];
  wire receive_enable_bit      = serial_mode_control[`ASMC_BIT_RXE];
  wire [1:0] parity_select     = {serial_mode_control[`ASMC_BIT_PS_HI],
                                  serial_mode_control[`ASMC_BIT_PS_LO]};
  wire character_length_select = serial_mode_control[`ASMC_BIT_CL];
  wire stop_length_select      = serial_mode_control[`ASMC_BIT_SL];
  wire [4:0] div_k             = baud_control_register[4:0];

  // Power is a flop output, so the derived reset is glitch free
  wire core_rst = sys_rst_in | ~unit_power_bit;  // [R1]

  wire wr_mode = wr_en_in && (addr_in == `ASMC_ADDR_MODE);
  wire wr_txs  = wr_en_in && (addr_in == `ASMC_ADDR_TXSHIFT);
  wire rd_err  = rd_en_in && (addr_in == `ASMC_ADDR_ERR);
  wire rd_rxb  = rd_en_in && (addr_in == `ASMC_ADDR_RXBUF);

  function parity_of;
    input [7:0] data;
    input       cl8;
    input [1:0] ps;
    reg         ones;
    begin
      ones = ^{data[7] & cl8, data[6:0]};
      case (ps)
        `ASMC_PS_ODD:  parity_of = ~ones;  // [R15]
        `ASMC_PS_EVEN: parity_of = ones;   // [R15]
        default:       parity_of = 1'b0;
      endcase
    end
  endfunction

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_mode_control   <= `ASMC_MODE_RESET;      // [R9]
      baud_control_register <= `ASMC_BAUD_RESET;
      port1_direction       <= `ASMC_PORT1DIR_RESET;  // [R10]
    end else if (wr_en_in) begin
      if (wr_mode)
        serial_mode_control <= wr_data_in | `ASMC_MODE_RESET;  // [R9]
      if (addr_in == `ASMC_ADDR_BAUD)
        baud_control_register <= {wr_data_in[7:6], 1'b0, wr_data_in[4:0]};
      if (addr_in == `ASMC_ADDR_PORT1DIR)
        port1_direction <= wr_data_in;
    end
  end

  // Base clock: prescaler tick or timer edge, held still while powered down
  reg  [6:0] pre_cnt;
  reg        tmr_s1;
  reg        tmr_s2;
  reg        tmr_s3;
  reg        base_tick;
  wire [6:0] pre_div = (baud_control_register[7:6] == 2'b01) ? `ASMC_DIV_SEL1 :
                       (baud_control_register[7:6] == 2'b10) ? `ASMC_DIV_SEL2 :
                       `ASMC_DIV_SEL3;
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      pre_cnt   <= 7'h00;
      tmr_s1    <= 1'b0;
      tmr_s2    <= 1'b0;
      tmr_s3    <= 1'b0;
      base_tick <= 1'b0;
    end else begin
      tmr_s1 <= timer_clk_in;
      tmr_s2 <= tmr_s1;
      tmr_s3 <= tmr_s2;
      if (baud_control_register[7:6] == 2'b00) begin
        base_tick <= tmr_s2 & ~tmr_s3;
      end else begin
        base_tick <= (pre_cnt == pre_div - 7'd1);
        pre_cnt   <= (pre_cnt >= pre_div - 7'd1) ? 7'h00 : pre_cnt + 7'd1;
      end
    end
  end

  // Enables take effect on a base clock edge; their reset from power-off is asynchronous
  reg txe_sync;
  reg rxe_sync;
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      txe_sync <= 1'b0;
      rxe_sync <= 1'b0;
    end else if (base_tick) begin
      txe_sync <= transmit_enable_bit;  // [R2]
      rxe_sync <= receive_enable_bit;   // [R3]
    end
  end

  // Two-entry transmit buffer; a full buffer refuses the write
  reg  [7:0] tx_mem [0:1];
  reg        tx_wp;
  reg        tx_rp;
  reg  [1:0] tx_cnt;
  wire       txb_ready = (tx_cnt != 2'd2) && transmit_enable_bit;
  wire       txb_valid = (tx_cnt != 2'd0);
  reg        tx_state;
  wire       tx_pop    = txb_valid && (tx_state == TX_IDLE) && txe_sync && base_tick;
  wire       tx_push   = wr_txs && txb_ready;
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      tx_wp     <= 1'b0;
      tx_rp     <= 1'b0;
      tx_cnt    <= 2'd0;
      tx_mem[0] <= 8'h00;
      tx_mem[1] <= 8'h00;
    end else if (!transmit_enable_bit) begin
      tx_wp  <= 1'b0;  // [R2]
      tx_rp  <= 1'b0;
      tx_cnt <= 2'd0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= wr_data_in;
        tx_wp         <= ~tx_wp;
      end
      if (tx_pop)
        tx_rp <= ~tx_rp;
      tx_cnt <= tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
    end
  end

  // Transmitter: one bit lasts 2k base ticks
  reg  [11:0] tx_frame;
  reg  [3:0]  tx_bits;
  reg  [5:0]  tx_tick;
  reg         tx_line;
  wire [7:0]  tx_data = tx_mem[tx_rp];
  wire        tx_par  = parity_of(tx_data, character_length_select, parity_select);
  wire        tx_pen  = (parity_select != `ASMC_PS_NONE);
  wire [5:0]  bit_len = {div_k, 1'b0};
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      tx_state <= TX_IDLE;
      tx_frame <= 12'hFFF;
      tx_bits  <= 4'h0;
      tx_tick  <= 6'h00;
      tx_line  <= 1'b1;
      tx_done_out <= 1'b0;
    end else begin
      tx_done_out <= 1'b0;
      if (!txe_sync) begin
        tx_state <= TX_IDLE;  // [R2]
        tx_line  <= 1'b1;     // [R21]
      end else begin
        case (tx_state)
          TX_IDLE: begin
            tx_line <= 1'b1;  // [R18]
            if (tx_pop) begin
              // Start, LSB-first data, parity, stops; unused high bits are stop level
              if (character_length_select)
                tx_frame <= {2'b11, tx_pen ? tx_par : 1'b1, tx_data, 1'b0};  // [R14]
              else
                tx_frame <= {3'b111, tx_pen ? tx_par : 1'b1, tx_data[6:0], 1'b0};  // [R18]
              tx_bits  <= 4'd2 + {3'b000, character_length_select} +
                          {3'b000, tx_pen} + {3'b000, stop_length_select} + 4'd7;  // [R16]
              tx_tick  <= 6'h00;
              tx_state <= TX_SEND;
            end
          end
          TX_SEND: begin
            tx_line <= tx_frame[0];  // [R17]
            if (base_tick) begin
              if (tx_tick == bit_len - 6'd1) begin
                tx_tick  <= 6'h00;
                tx_frame <= {1'b1, tx_frame[11:1]};
                tx_bits  <= tx_bits - 4'd1;
                if (tx_bits == 4'd1) begin
                  tx_state    <= TX_IDLE;
                  tx_done_out <= 1'b1;
                end
              end else begin
                tx_tick <= tx_tick + 6'd1;
              end
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
        if (tx_state == TX_IDLE && !tx_pop)
          tx_line <= 1'b1;
      end
    end
  end

  // Receive input: two-flop sync, then base-clock match filter
  reg  rx_s1;
  reg  rx_s2;
  reg  rx_f1;
  reg  rx_filt;
  reg  rx_prev;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin_in;
      rx_s2 <= rx_s1;
    end
  end
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      rx_f1   <= 1'b1;  // [R4]
      rx_filt <= 1'b1;  // [R4]
      rx_prev <= 1'b1;
    end else if (base_tick) begin
      rx_f1   <= rx_s2;
      rx_prev <= rx_filt;
      if (rx_f1 == rx_s2)
        rx_filt <= rx_s2;
    end
  end

  reg  [1:0] rx_state;
  reg  [5:0] rx_tick;
  reg  [3:0] rx_idx;
  reg  [8:0] rx_shift;
  wire [3:0] rx_last = 4'd7 + {3'b000, character_length_select} +
                       {3'b000, parity_select != `ASMC_PS_NONE};  // [R19]
  wire [7:0] rx_data = character_length_select ? rx_shift[7:0] : {1'b0, rx_shift[6:0]};
  wire       rx_parb = character_length_select ? rx_shift[8] : rx_shift[7];
  wire       rx_pe   = parity_select[1] &&
                       (rx_parb != parity_of(rx_data, character_length_select, parity_select));
  // A frame cut by a receive disable must not report completion
  wire       rx_end  = rxe_sync && (rx_state == RX_DATA) && base_tick &&
                       (rx_tick == bit_len - 6'd1) && (rx_idx == rx_last);
  reg        rxb_full;
  wire       ove_now = rx_end && rxb_full && !rd_rxb;
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      rx_state <= RX_IDLE;
      rx_tick  <= 6'h00;
      rx_idx   <= 4'h0;
      rx_shift <= 9'h000;
    end else if (!rxe_sync) begin
      rx_state <= RX_IDLE;  // [R3]
    end else if (base_tick) begin
      case (rx_state)
        RX_IDLE: begin
          rx_tick <= 6'h00;
          if (rx_prev && !rx_filt)
            rx_state <= RX_START;
        end
        RX_START: begin
          // Recheck mid start bit so a short glitch is not taken as a frame
          if (rx_tick == {1'b0, div_k} - 6'd1) begin
            rx_tick  <= 6'h00;
            rx_idx   <= 4'h0;
            rx_state <= rx_filt ? RX_IDLE : RX_DATA;
          end else begin
            rx_tick <= rx_tick + 6'd1;
          end
        end
        RX_DATA: begin
          if (rx_tick == bit_len - 6'd1) begin
            rx_tick <= 6'h00;
            if (rx_idx == rx_last)
              rx_state <= RX_IDLE;  // [R19]
            else
              rx_shift[rx_idx] <= rx_filt;  // [R14]
            rx_idx <= rx_idx + 4'd1;
          end else begin
            rx_tick <= rx_tick + 6'd1;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer and error flags; a new error wins over a clearing read
  always @(posedge clk_in or posedge core_rst) begin
    if (core_rst) begin
      receive_buffer_register <= 8'h00;
      rxb_full             <= 1'b0;
      receive_error_status <= 3'b000;  // [R22]
      rx_done_out          <= 1'b0;
      rx_err_out           <= 1'b0;
    end else begin
      rx_done_out <= rx_end;
      rx_err_out  <= rx_end && (rx_pe || !rx_filt || ove_now);
      if (!receive_enable_bit)
        receive_error_status <= 3'b000;  // [R22]
      else if (rx_end)
        receive_error_status <= (rd_err ? 3'b000 : receive_error_status) |
                                {rx_pe, !rx_filt, ove_now};
      else if (rd_err)
        receive_error_status <= 3'b000;  // [R22]
      if (rx_end && !ove_now) begin
        receive_buffer_register <= rx_data;
        rxb_full                <= 1'b1;
      end else if (rd_rxb) begin
        rxb_full <= 1'b0;
      end
    end
  end

  // Read data and pin hand-over
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out   <= 8'h00;
      tx_pin_out    <= 1'b1;
      tx_pin_oe_out <= 1'b0;
      rx_pin_out    <= 1'b1;
      rx_pin_oe_out <= 1'b0;
      tx_ready_out  <= 1'b0;
    end else begin
      rd_data_out <= 8'h00;
      if (rd_en_in) begin
        case (addr_in)
          `ASMC_ADDR_MODE:     rd_data_out <= serial_mode_control;
          `ASMC_ADDR_BAUD:     rd_data_out <= baud_control_register;
          `ASMC_ADDR_RXBUF:    rd_data_out <= receive_buffer_register;
          `ASMC_ADDR_ERR:      rd_data_out <= {5'b00000, receive_error_status};
          `ASMC_ADDR_PORT1DIR: rd_data_out <= port1_direction;
          default:             rd_data_out <= 8'h00;
        endcase
      end
      tx_ready_out  <= txb_ready && unit_power_bit;
      tx_pin_oe_out <= ~port1_direction[`ASMC_BIT_TXPIN];  // [R10]
      rx_pin_oe_out <= ~port1_direction[`ASMC_BIT_RXPIN];  // [R10]
      rx_pin_out    <= port1_latch_in[`ASMC_BIT_RXPIN];    // [R5]
      if (unit_power_bit && transmit_enable_bit)
        tx_pin_out <= tx_line;  // [R13]
      else
        tx_pin_out <= port1_latch_in[`ASMC_BIT_TXPIN];  // [R5]
    end
  end

endmodule

// File: tb/asmc_line_partner.sv
// Remote station: drives frames into the unit and captures its frames.
// Assumes an idle-high line and a bit time set by the bench.
module asmc_line_partner #(
  parameter int BIT_NS = 3200  // Bit time
) (
  input  logic tx_line_in,  // Unit tx pin
  output logic rx_line_out  // Unit rx pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_line_out = 1'b1;
  task automatic send(input logic [7:0] d, input logic cl8, input logic [1:0] ps,
                      input logic [1:0] bad);
    logic [7:0] dm;
    dm = cl8 ? d : {1'b0, d[6:0]};
    rx_line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < (cl8 ? 8 : 7); i++) begin
      rx_line_out = dm[i];
      #(BIT_NS);
    end
    if (ps != 2'b00) begin
      rx_line_out = bad[0] ^ (ps == 2'b11 ? ^dm : (ps == 2'b10 ? ~^dm : 1'b0));
      #(BIT_NS);
    end
    rx_line_out = !bad[1];
    #(BIT_NS);
    rx_line_out = 1'b1;
    #(BIT_NS);
  endtask
  // Samples mid-bit; the last sample is the second stop or idle
  task automatic capture(input logic cl8, input logic [1:0] ps, output logic [7:0] d,
                         output logic par, output logic [2:0] frm);
    d = 8'h00;
    par = 1'b0;
    @(negedge tx_line_in);
    #(BIT_NS / 2);
    frm[0] = tx_line_in;
    for (int i = 0; i < (cl8 ? 8 : 7); i++) begin
      #(BIT_NS);
      d[i] = tx_line_in;
    end
    if (ps != 2'b00) begin
      #(BIT_NS);
      par = tx_line_in;
    end
    #(BIT_NS);
    frm[1] = tx_line_in;
    #(BIT_NS);
    frm[2] = tx_line_in;
  endtask
endmodule

// File: tb/asmc_serial_unit_asserts.sv
// Checker on the serial unit's ports.
// Assumes the register map of the shared defines header.
`include "asmc_defines.vh"
module asmc_serial_unit_chk (
  input logic        clk_in,         // Clock
  input logic        sys_rst_in,     // Reset
  input logic [15:0] addr_in,        // Address
  input logic [7:0]  wr_data_in,     // Write data
  input logic        wr_en_in,       // Write strobe
  input logic        rd_en_in,       // Read strobe
  input logic [7:0]  port1_latch_in, // Latches
  input logic [7:0]  rd_data_out,    // Read data
  input logic        tx_pin_out,     // Tx pin
  input logic        tx_pin_oe_out,  // Tx drive
  input logic        rx_pin_oe_out,  // Rx drive
  input logic        tx_ready_out,   // Room
  input logic        tx_done_out,    // Sent
  input logic        rx_done_out,    // Received
  input logic        rx_err_out      // Bad frame
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  wire wr_mode = wr_en_in && addr_in == `ASMC_ADDR_MODE;
  wire wr_dir  = wr_en_in && addr_in == `ASMC_ADDR_PORT1DIR;
  wire rd_err  = rd_en_in && addr_in == `ASMC_ADDR_ERR;
  wire quiet   = !rx_done_out;
  property p_mode_bit0; rd_en_in && addr_in == `ASMC_ADDR_MODE |=> rd_data_out[0]; endproperty
  a_mode_bit0: assert property (p_mode_bit0) else $error("mode bit 0 low");
  property p_err_clear; (rd_err && quiet) ##1 quiet ##1 (rd_err && quiet) ##1 quiet
    |-> rd_data_out == 8'h00; endproperty
  a_err_clear: assert property (p_err_clear) else $error("status kept");
  property p_tx_oe; wr_dir |-> ##2 tx_pin_oe_out == !$past(wr_data_in[4], 2); endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("tx drive wrong");
  property p_rx_oe; wr_dir |-> ##2 rx_pin_oe_out == !$past(wr_data_in[3], 2); endproperty
  a_rx_oe: assert property (p_rx_oe) else $error("rx drive wrong");
  property p_err_done; rx_err_out |-> rx_done_out; endproperty
  a_err_done: assert property (p_err_done) else $error("lone error");
  property p_done_high; tx_done_out |-> tx_pin_out && !$past(tx_done_out); endproperty
  a_done_high: assert property (p_done_high) else $error("line low at end");
  property p_ready_off; wr_mode && !wr_data_in[6] |=> ##[1:2] !tx_ready_out; endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready with tx off");
  property p_port_off; (wr_mode && wr_data_in[7:6] != 2'b11) ##1 !wr_mode [*3]
    |-> tx_pin_out == $past(port1_latch_in[4]); endproperty
  a_port_off: assert property (p_port_off) else $error("pin not port");
  c_tx: cover property (tx_done_out);
  c_err: cover property (rx_err_out);
  c_rx: cover property (rx_done_out && !rx_err_out);
endmodule
bind asmc_serial_unit asmc_serial_unit_chk u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .port1_latch_in(port1_latch_in),
  .rd_data_out(rd_data_out), .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
  .rx_pin_oe_out(rx_pin_oe_out), .tx_ready_out(tx_ready_out), .tx_done_out(tx_done_out),
  .rx_done_out(rx_done_out), .rx_err_out(rx_err_out));

// File: tb/tb_top.sv
// Bench for the serial unit: register port, pin hand-over, frames both ways.
// Assumes the line partner; base clock is clk / 4 and k = 8, so a bit is 64 clocks.
`include "asmc_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         BIT_NS = 3200;
  localparam logic [7:0] FMT [4] = '{8'h1D, 8'h13, 8'h0D, 8'h03};
  localparam logic [7:0] DAT [4] = '{8'h55, 8'h36, 8'h87, 8'h2A};
  logic        clk_in, sys_rst_in, wr_en_in, rd_en_in, timer_clk_in, rx_pin_in;
  logic [15:0] addr_in;
  logic [7:0]  wr_data_in, port1_latch_in, rd_data_out, cd;
  logic        tx_pin_out, tx_pin_oe_out, rx_pin_out, rx_pin_oe_out, cp;
  logic        tx_ready_out, tx_done_out, rx_done_out, rx_err_out;
  logic [2:0]  cf;
  int          n_errors, num_checks, n_txd, n_rxd, n_rxe, t0, nt;
  asmc_serial_unit dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .timer_clk_in(timer_clk_in),
    .port1_latch_in(port1_latch_in), .rx_pin_in(rx_pin_in), .rd_data_out(rd_data_out),
    .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out), .rx_pin_out(rx_pin_out),
    .rx_pin_oe_out(rx_pin_oe_out), .tx_ready_out(tx_ready_out), .tx_done_out(tx_done_out),
    .rx_done_out(rx_done_out), .rx_err_out(rx_err_out));
  asmc_line_partner #(.BIT_NS(BIT_NS)) partner (.tx_line_in(tx_pin_out), .rx_line_out(rx_pin_in));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    n_txd <= n_txd + (tx_done_out === 1'b1);
    n_rxd <= n_rxd + (rx_done_out === 1'b1);
    n_rxe <= n_rxe + (rx_err_out === 1'b1);
  end
  function automatic logic exp_par(input logic [7:0] d, input logic [1:0] ps);
    return (ps == 2'b11) ? ^d : ((ps == 2'b10) ? ~^d : 1'b0);
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  // Data is read one settle step after the taking edge, before it falls back to 0
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    check(rd_data_out, exp);
  endtask
  task automatic pins(input logic [3:0] exp);
    wait_clk(2);
    #1;
    check({4'h0, tx_pin_oe_out, rx_pin_oe_out, tx_pin_out, rx_pin_out}, {4'h0, exp});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(BIT_NS * 300);
    n_errors++;
    end_of_test();
  end
  initial begin
    {n_errors, num_checks, n_txd, n_rxd, n_rxe} = '0;
    sys_rst_in = 1'b1;
    addr_in = 16'h0000;
    wr_data_in = 8'h00;
    {wr_en_in, rd_en_in, timer_clk_in} = 3'b000;
    port1_latch_in = 8'h00;
    wait_clk(2);
    sys_rst_in <= 1'b0;
    rd_chk(`ASMC_ADDR_MODE, `ASMC_MODE_RESET);
    rd_chk(`ASMC_ADDR_PORT1DIR, `ASMC_PORT1DIR_RESET);
    rd_chk(`ASMC_ADDR_ERR, `ASMC_ERR_RESET);
    rd_chk(16'hFF50, 8'h00);
    pins(4'b0000);
    wr(`ASMC_ADDR_BAUD, 8'h48);
    wr(`ASMC_ADDR_PORT1DIR, 8'hEF);
    pins(4'b1000);
    wr(`ASMC_ADDR_MODE, 8'h80);
    rd_chk(`ASMC_ADDR_MODE, 8'h81);
    pins(4'b1000);
    check({7'h0, tx_ready_out}, 8'h00);
    @(posedge clk_in);
    port1_latch_in <= 8'h18;
    pins(4'b1011);
    $display("test pins done");
    for (int f = 0; f < 4; f++) begin
      wr(`ASMC_ADDR_MODE, 8'h80 | FMT[f]);
      wait_clk(12);
      wr(`ASMC_ADDR_MODE, 8'hE0 | FMT[f]);
      rd_chk(`ASMC_ADDR_MODE, 8'hE0 | FMT[f]);
      wait_clk(12);
      check({7'h0, tx_ready_out}, 8'h01);
      t0 = n_txd;
      fork
        begin
          partner.capture(FMT[f][2], FMT[f][4:3], cd, cp, cf);
          nt = n_txd;
        end
        partner.send(DAT[f], FMT[f][2], FMT[f][4:3], 2'b00);
        wr(`ASMC_ADDR_TXSHIFT, DAT[f]);
      join
      check(cd, DAT[f]);
      check({7'h0, cp}, {7'h0, exp_par(DAT[f], FMT[f][4:3])});
      check({5'h0, cf}, 8'h06);
      check(8'(nt - t0), {7'h0, !FMT[f][1]});
      rd_chk(`ASMC_ADDR_ERR, 8'h00);
      rd_chk(`ASMC_ADDR_RXBUF, DAT[f]);
      $display("test format %0d done", f);
    end
    fork
      begin
        partner.capture(1'b0, 2'b00, cd, cp, cf);
        check(cd, 8'h11);
        partner.capture(1'b0, 2'b00, cd, cp, cf);
        check(cd, 8'h22);
      end
      begin
        wr(`ASMC_ADDR_TXSHIFT, 8'h11);
        wr(`ASMC_ADDR_TXSHIFT, 8'h22);
      end
    join
    wr(`ASMC_ADDR_MODE, 8'h9D);
    wait_clk(12);
    wr(`ASMC_ADDR_MODE, 8'hFD);
    partner.send(8'hA5, 1'b1, 2'b11, 2'b01);
    rd_chk(`ASMC_ADDR_ERR, 8'h04);
    rd_chk(`ASMC_ADDR_ERR, 8'h00);
    rd_chk(`ASMC_ADDR_RXBUF, 8'hA5);
    partner.send(8'h3C, 1'b1, 2'b11, 2'b10);
    rd_chk(`ASMC_ADDR_ERR, 8'h02);
    partner.send(8'h5A, 1'b1, 2'b11, 2'b00);
    check(8'(n_rxe), 8'h03);
    wr(`ASMC_ADDR_MODE, 8'hDD);
    rd_chk(`ASMC_ADDR_ERR, 8'h00);
    $display("test errors done");
    wr(`ASMC_ADDR_MODE, 8'h01);
    @(posedge clk_in);
    port1_latch_in <= 8'h08;
    pins(4'b1001);
    t0 = n_rxd;
    partner.send(8'h00, 1'b1, 2'b00, 2'b00);
    wr(`ASMC_ADDR_MODE, 8'hBD);
    wait_clk(40);
    check(8'(n_rxd - t0), 8'h00);
    $display("test power off done");
    end_of_test();
  end
endmodule
